// ===== rtl/ppav_pkg.sv
package ppav_pkg;

    // Management access widths
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;

    // Management register addresses
    localparam logic [4:0] ADDR_PARTNER = 5'h05;
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_VENDOR = 5'h10;

    // Reset values
    localparam logic [15:0] RESET_PARTNER = 16'h0000;
    localparam logic [15:0] RESET_EXPANSION = 16'h0000;
    localparam logic [15:0] RESET_VENDOR = 16'h0140;

    // Partner ability field positions
    localparam int unsigned PA_RF_BIT = 13;
    localparam int unsigned PA_ABIL_MSB = 12;
    localparam int unsigned PA_ABIL_LSB = 5;
    localparam int unsigned PA_SEL_MSB = 4;
    localparam int unsigned PA_SEL_LSB = 0;
    localparam int unsigned ABIL_10T_FD = 6;
    localparam int unsigned PA_10T_FD_BIT = PA_ABIL_LSB + ABIL_10T_FD;

    // Expansion field positions
    localparam int unsigned EXP_CAPABLE_BIT = 0;

    // Vendor configuration field positions
    localparam int unsigned VC_UPPER_LSB = 6;
    localparam int unsigned VC_POL_DIS = 5;
    localparam int unsigned VC_RX_INV = 4;
    localparam int unsigned VC_BYPASS = 1;
    localparam int unsigned VC_GATE = 0;
    localparam logic [1:0] VC_RSVD_VALUE = 2'h0;
    localparam logic [9:0] RESET_VC_UPPER = RESET_VENDOR[15:6];

    // Selector codes
    localparam logic [4:0] SEL_RESERVED = 5'h00;
    localparam logic [4:0] SEL_IEEE8023 = 5'h01;
    localparam logic [4:0] SEL_IEEE8029 = 5'h02;
    localparam logic [4:0] SEL_IEEE8025 = 5'h03;
    localparam logic [4:0] SEL_IEEE1394 = 5'h04;

    // Decoded partner protocol
    typedef enum logic [2:0] {
        PPAV_PROTO_RESERVED = 3'h0,
        PPAV_PROTO_8023 = 3'h1,
        PPAV_PROTO_8029 = 3'h2,
        PPAV_PROTO_8025 = 3'h3,
        PPAV_PROTO_1394 = 3'h4
    } ppav_proto_t;

    // Selector code to protocol, higher codes reserved
    function automatic ppav_proto_t ppav_decode_selector(input logic [4:0] sel);
        ppav_proto_t proto;
        proto = PPAV_PROTO_RESERVED;
        if (sel == SEL_IEEE8023) begin
            proto = PPAV_PROTO_8023;
        end else if (sel == SEL_IEEE8029) begin
            proto = PPAV_PROTO_8029;
        end else if (sel == SEL_IEEE8025) begin
            proto = PPAV_PROTO_8025;
        end else if (sel == SEL_IEEE1394) begin
            proto = PPAV_PROTO_1394;
        end
        return proto;
    endfunction : ppav_decode_selector

endpackage : ppav_pkg

// ===== rtl/ppav_polarity.sv
`timescale 1ns/1ps
// Automatic receive polarity tracker
module ppav_polarity (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic correction_disable_in,
    input wire logic mode_10baset_in,
    input wire logic autoneg_active_in,
    input wire logic polarity_reversed_in,
    output logic auto_inversion_out
);

    logic auto_inversion_reg;
    logic auto_inversion_next;
    wire sample_enable;

    // Detection window: correction on, 10Base-T, negotiation running
    assign sample_enable = !correction_disable_in && mode_10baset_in && autoneg_active_in;
    assign auto_inversion_next = sample_enable ? polarity_reversed_in : auto_inversion_reg;

    // Holds last detected pair orientation
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            auto_inversion_reg <= 1'b0;
        end else begin
            auto_inversion_reg <= auto_inversion_next;
        end
    end

    assign auto_inversion_out = auto_inversion_reg;

    // Detector follows reversed pair inside window
    auto_track_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        sample_enable |=> auto_inversion_reg == $past(polarity_reversed_in))
        else $error("auto polarity did not follow detector");

    // Detector frozen outside window
    auto_hold_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        !sample_enable |=> $stable(auto_inversion_reg))
        else $error("auto polarity changed outside window");

endmodule : ppav_polarity

// ===== rtl/ppav_regs.sv
`timescale 1ns/1ps
// How it works
// - Partner base page captured into read-only address 0x05, reset zero.
// - Bit 13 of partner register reports partner remote fault, read-only.
// - Bits 12:5 hold partner eight-bit technology ability field, read-only.
// - Bits 4:0 hold partner five-bit selector field, read-only.
// - Selector decodes 1 802.3, 2 802.9, 3 802.5, 4 1394, else reserved.
// - Read-only expansion register at 0x06 reports negotiation capabilities, reset zero.
// - Expansion bit 0 is one when partner found negotiation capable.
// - Vendor configuration register at 0x10 resets to 0x0140.
// - Vendor bit 5 set turns automatic polarity correction off.
// - With correction on in 10Base-T, reversed pair detected while negotiation is active and inverted.
// - Correction on: bit 4 is read-only automatic inversion status.
// - Correction off: bit 4 writable, forces or clears receive inversion.
// - Vendor bits 3:2 reserved, read-only, read as zero.
// - Vendor bit 1 routes 100Base-TX around coding sublayer and scrambler.
// - Bit 0 with 100Base-TX stops receive clock while no data arrives.
// - Loopback forces clock gating off regardless of gating enable bit.
// - Ability field position 6 means partner supports 10Base-T full duplex.
module ppav_regs (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [4:0] mgmt_addr_in,
    input wire logic mgmt_write_in,
    input wire logic [15:0] mgmt_wdata_in,
    input wire logic mgmt_read_in,
    output logic [15:0] mgmt_rdata_out,
    output logic mgmt_rvalid_out,
    input wire logic partner_page_valid_in,
    input wire logic [15:0] partner_page_in,
    input wire logic partner_autoneg_capable_in,
    input wire logic autoneg_restart_in,
    input wire logic autoneg_active_in,
    input wire logic mode_10baset_in,
    input wire logic mode_100basetx_in,
    input wire logic loopback_select_in,
    input wire logic polarity_reversed_in,
    input wire logic rx_data_active_in,
    output logic receive_inversion_out,
    output logic coding_bypass_out,
    output logic rx_clock_stop_out,
    output logic remote_fault_out,
    output logic partner_10t_full_duplex_out,
    output logic [2:0] partner_protocol_out
);

    // Stored state
    logic [15:0] partner_reg;
    logic [15:0] partner_next;
    logic capable_reg;
    logic capable_next;
    logic [9:0] vc_upper_reg;
    logic [9:0] vc_upper_next;
    logic pol_dis_reg;
    logic pol_dis_next;
    logic forced_inv_reg;
    logic forced_inv_next;
    logic bypass_reg;
    logic bypass_next;
    logic gate_en_reg;
    logic gate_en_next;

    // Output flops
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rvalid_reg;
    logic inversion_reg;
    logic inversion_next;
    logic bypass_out_reg;
    logic clock_stop_reg;
    logic clock_stop_next;
    logic rf_reg;
    logic fd10_reg;
    ppav_pkg::ppav_proto_t proto_reg;
    ppav_pkg::ppav_proto_t proto_next;

    logic auto_inversion;
    wire hit_partner;
    wire hit_expansion;
    wire hit_vendor;
    wire wr_vendor;
    wire inv_view;
    wire [15:0] partner_view;
    wire [15:0] expansion_view;
    wire [15:0] vendor_view;

    // Automatic polarity detector
    ppav_polarity u_polarity (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .correction_disable_in(pol_dis_reg),
        .mode_10baset_in(mode_10baset_in),
        .autoneg_active_in(autoneg_active_in),
        .polarity_reversed_in(polarity_reversed_in),
        .auto_inversion_out(auto_inversion)
    );

    // Address decode
    assign hit_partner = (mgmt_addr_in == ppav_pkg::ADDR_PARTNER);
    assign hit_expansion = (mgmt_addr_in == ppav_pkg::ADDR_EXPANSION);
    assign hit_vendor = (mgmt_addr_in == ppav_pkg::ADDR_VENDOR);
    assign wr_vendor = mgmt_write_in && hit_vendor;

    // Partner page captured only from negotiation, never from writes
    assign partner_next = partner_page_valid_in ? partner_page_in : partner_reg;

    // Capability flag: new page result wins over restart clear
    assign capable_next = partner_page_valid_in ? partner_autoneg_capable_in :
                          autoneg_restart_in ? 1'b0 : capable_reg;

    // Vendor writable fields
    assign vc_upper_next = wr_vendor ? mgmt_wdata_in[15:6] : vc_upper_reg;
    assign pol_dis_next = wr_vendor ? mgmt_wdata_in[ppav_pkg::VC_POL_DIS] : pol_dis_reg;
    assign bypass_next = wr_vendor ? mgmt_wdata_in[ppav_pkg::VC_BYPASS] : bypass_reg;
    assign gate_en_next = wr_vendor ? mgmt_wdata_in[ppav_pkg::VC_GATE] : gate_en_reg;

    // Bit 4 accepts writes only when correction is being disabled
    assign forced_inv_next = (wr_vendor && mgmt_wdata_in[ppav_pkg::VC_POL_DIS]) ?
                             mgmt_wdata_in[ppav_pkg::VC_RX_INV] : forced_inv_reg;

    // Bit 4 shows automatic status or forced value
    assign inv_view = pol_dis_reg ? forced_inv_reg : auto_inversion;

    // Read views
    assign partner_view = partner_reg;
    assign expansion_view = {15'h0000, capable_reg};
    assign vendor_view = {vc_upper_reg, pol_dis_reg, inv_view, ppav_pkg::VC_RSVD_VALUE,
                          bypass_reg, gate_en_reg};

    // Read mux, unmapped reads return zero
    assign rdata_next = !mgmt_read_in ? rdata_reg :
                        hit_partner ? partner_view :
                        hit_expansion ? expansion_view :
                        hit_vendor ? vendor_view : 16'h0000;

    // Datapath controls
    assign inversion_next = pol_dis_reg ? forced_inv_reg : auto_inversion;
    assign clock_stop_next = gate_en_reg && mode_100basetx_in && !loopback_select_in &&
                             !rx_data_active_in;
    assign proto_next = ppav_pkg::ppav_decode_selector(
        partner_reg[ppav_pkg::PA_SEL_MSB:ppav_pkg::PA_SEL_LSB]);

    // Partner capture and expansion flag
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            partner_reg <= ppav_pkg::RESET_PARTNER;
            capable_reg <= ppav_pkg::RESET_EXPANSION[0];
        end else begin
            partner_reg <= partner_next;
            capable_reg <= capable_next;
        end
    end

    // Vendor configuration storage
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            vc_upper_reg <= ppav_pkg::RESET_VC_UPPER;
            pol_dis_reg <= ppav_pkg::RESET_VENDOR[ppav_pkg::VC_POL_DIS];
            forced_inv_reg <= ppav_pkg::RESET_VENDOR[ppav_pkg::VC_RX_INV];
            bypass_reg <= ppav_pkg::RESET_VENDOR[ppav_pkg::VC_BYPASS];
            gate_en_reg <= ppav_pkg::RESET_VENDOR[ppav_pkg::VC_GATE];
        end else begin
            vc_upper_reg <= vc_upper_next;
            pol_dis_reg <= pol_dis_next;
            forced_inv_reg <= forced_inv_next;
            bypass_reg <= bypass_next;
            gate_en_reg <= gate_en_next;
        end
    end

    // Management read answer
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= mgmt_read_in;
        end
    end

    // Registered control and status outputs
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            inversion_reg <= 1'b0;
            bypass_out_reg <= 1'b0;
            clock_stop_reg <= 1'b0;
            rf_reg <= 1'b0;
            fd10_reg <= 1'b0;
            proto_reg <= ppav_pkg::PPAV_PROTO_RESERVED;
        end else begin
            inversion_reg <= inversion_next;
            bypass_out_reg <= bypass_reg;
            clock_stop_reg <= clock_stop_next;
            rf_reg <= partner_reg[ppav_pkg::PA_RF_BIT];
            fd10_reg <= partner_reg[ppav_pkg::PA_10T_FD_BIT];
            proto_reg <= proto_next;
        end
    end

    // Port drive
    assign mgmt_rdata_out = rdata_reg;
    assign mgmt_rvalid_out = rvalid_reg;
    assign receive_inversion_out = inversion_reg;
    assign coding_bypass_out = bypass_out_reg;
    assign rx_clock_stop_out = clock_stop_reg;
    assign remote_fault_out = rf_reg;
    assign partner_10t_full_duplex_out = fd10_reg;
    assign partner_protocol_out = proto_reg;

    default clocking ppav_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    // Page capture lands in partner register
    page_capture_a: assert property (partner_page_valid_in |=>
        partner_reg == $past(partner_page_in))
        else $error("partner page not captured");

    // Remote fault output follows captured page two cycles on
    remote_fault_a: assert property (partner_page_valid_in |=> ##1
        remote_fault_out == $past(partner_page_in[ppav_pkg::PA_RF_BIT], 2))
        else $error("remote fault output wrong");

    // Ability field readback
    ability_read_a: assert property (mgmt_read_in && hit_partner |=>
        mgmt_rdata_out[12:5] == $past(partner_reg[12:5]))
        else $error("ability field readback wrong");

    // Selector field readback
    selector_read_a: assert property (mgmt_read_in && hit_partner |=>
        mgmt_rdata_out[4:0] == $past(partner_reg[4:0]))
        else $error("selector readback wrong");

    // Selector decode, codes above 1394 reserved
    selector_decode_a: assert property (1'b1 |=>
        partner_protocol_out == (($past(partner_reg[4:0]) > ppav_pkg::SEL_IEEE1394) ? 3'h0 :
        $past(partner_reg[2:0])))
        else $error("selector decode wrong");

    // Expansion flag captures capability with the page
    expansion_flag_a: assert property (partner_page_valid_in |=>
        expansion_view == {15'h0000, $past(partner_autoneg_capable_in)})
        else $error("expansion flag wrong");

    // Vendor register value right after reset
    vendor_reset_a: assert property ($fell(reset_in) |->
        vendor_view[15:6] == ppav_pkg::RESET_VENDOR[15:6] && !pol_dis_reg && !bypass_reg
        && !gate_en_reg)
        else $error("vendor reset value wrong");

    // Automatic inversion reaches datapath while correction on
    auto_polarity_a: assert property (!pol_dis_reg && mode_10baset_in && autoneg_active_in
        && !pol_dis_next |=> ##1 receive_inversion_out == $past(polarity_reversed_in, 2))
        else $error("automatic inversion not applied");

    // Bit 4 write ignored while correction stays on
    status_readonly_a: assert property (wr_vendor && !mgmt_wdata_in[5] |=>
        $stable(forced_inv_reg))
        else $error("polarity status written while read-only");

    // Forced inversion reaches datapath
    forced_polarity_a: assert property (wr_vendor && mgmt_wdata_in[5] |=> ##1
        receive_inversion_out == $past(mgmt_wdata_in[4], 2))
        else $error("forced inversion not applied");

    // Reserved bits read zero
    reserved_zero_a: assert property (mgmt_read_in && hit_vendor |=>
        mgmt_rdata_out[3:2] == 2'h0)
        else $error("reserved bits not zero");

    // Bypass control follows written bit
    bypass_follow_a: assert property (wr_vendor |=> ##1
        coding_bypass_out == $past(mgmt_wdata_in[1], 2))
        else $error("bypass control wrong");

    // Clock stop only when enabled, 100Base-TX and idle
    clock_gate_a: assert property (rx_clock_stop_out |->
        $past(gate_en_reg) && $past(mode_100basetx_in) && !$past(rx_data_active_in))
        else $error("receive clock stopped without cause");

    // Loopback overrides gating
    loopback_gate_a: assert property (loopback_select_in |=> !rx_clock_stop_out)
        else $error("clock gated during loopback");

    // Full duplex flag tracks ability position 6
    fd10_flag_a: assert property (1'b1 |=>
        partner_10t_full_duplex_out == $past(partner_reg[11]))
        else $error("10Base-T full duplex flag wrong");

    // Writes to partner register ignored
    partner_readonly_a: assert property (mgmt_write_in && hit_partner && !partner_page_valid_in
        |=> $stable(partner_reg))
        else $error("partner register changed by write");

endmodule : ppav_regs

// ===== verif/ppav_partner_model.sv
`timescale 1ns/1ps
// Link partner seen through the negotiation engine: base pages with a strobe
module ppav_partner_model (
    input wire logic clk_in,
    input wire logic send_in,
    input wire logic [15:0] word_in,
    input wire logic capable_in,
    output logic page_valid_out,
    output logic [15:0] page_out,
    output logic capable_out
);
    logic [15:0] last_reg = 16'h0000;

    // Remember the last page so the idle bus can show its inverse
    always_ff @(posedge clk_in) begin
        if (send_in) begin
            last_reg <= word_in;
        end
    end

    // Word and ability flag qualified by the strobe only; idle lines carry junk
    assign page_valid_out = send_in;
    assign page_out = send_in ? word_in : ~last_reg;
    assign capable_out = send_in ? capable_in : ~capable_in;
endmodule : ppav_partner_model

// ===== verif/tb_ppav_regs.sv
`timescale 1ns/1ps
// Self-checking bench for the partner, expansion and vendor registers
module tb_ppav_regs;
    localparam logic [15:0] PAGES [6] = '{16'h2000, 16'h1fa1, 16'h2042, 16'h0803, 16'h3fe4,
        16'h001f};
    logic clk_sys_in, reset_in, wr, rd, p_send, p_cap, pg_valid, pg_cap, restart, an_active;
    logic m10, m100, loopback, reversed, rx_active, rx_inv, bypass, clk_stop, rf, fd10, rvalid;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, p_word, pg_word;
    logic [2:0] proto;
    logic [4:0] sel;
    int mismatches = 0;
    int cmp_count = 0;

    ppav_partner_model i_partner (.clk_in(clk_sys_in), .send_in(p_send), .word_in(p_word),
        .capable_in(p_cap), .page_valid_out(pg_valid), .page_out(pg_word),
        .capable_out(pg_cap));

    ppav_regs i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .mgmt_addr_in(addr),
        .mgmt_write_in(wr), .mgmt_wdata_in(wdata), .mgmt_read_in(rd),
        .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid), .partner_page_valid_in(pg_valid),
        .partner_page_in(pg_word), .partner_autoneg_capable_in(pg_cap),
        .autoneg_restart_in(restart), .autoneg_active_in(an_active),
        .mode_10baset_in(m10), .mode_100basetx_in(m100), .loopback_select_in(loopback),
        .polarity_reversed_in(reversed), .rx_data_active_in(rx_active),
        .receive_inversion_out(rx_inv), .coding_bypass_out(bypass),
        .rx_clock_stop_out(clk_stop), .remote_fault_out(rf),
        .partner_10t_full_duplex_out(fd10), .partner_protocol_out(proto));

    // 100 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // Word comparison, counted
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic mwrite(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_sys_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_sys_in);
        wr = 1'b0;
    endtask : mwrite

    // One-cycle read strobe; answer due exactly one cycle later
    task automatic mread(input logic [4:0] a, input logic [15:0] exp);
        @(negedge clk_sys_in);
        addr = a;
        rd = 1'b1;
        @(negedge clk_sys_in);
        rd = 1'b0;
        chk("read valid", 16'h0001, {15'h0000, rvalid});
        chk($sformatf("read %h", a), exp, rdata);
    endtask : mread

    // Partner delivers one base page
    task automatic send(input logic [15:0] w, input logic c);
        @(negedge clk_sys_in);
        p_word = w;
        p_cap = c;
        p_send = 1'b1;
        @(negedge clk_sys_in);
        p_send = 1'b0;
        repeat (2) @(negedge clk_sys_in);
    endtask : send

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : idle

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    // Watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        mismatches++;
        wrap_up();
    end

    // Test sequence
    initial begin
        {wr, rd, p_send, p_cap, restart, an_active, m10, m100} = 8'h00;
        {loopback, reversed, rx_active} = 3'h0;
        addr = 5'h00;
        wdata = 16'h0000;
        p_word = 16'h0000;
        reset_in = 1'b1;
        idle(3);
        reset_in = 1'b0;
        mread(5'h05, 16'h0000);
        mread(5'h06, 16'h0000);
        mread(5'h10, 16'h0140);
        mread(5'h1f, 16'h0000);
        $display("test reset_values done");
        for (int i = 0; i < 6; i++) begin
            sel = PAGES[i][4:0];
            send(PAGES[i], 1'(i % 2));
            mread(5'h05, PAGES[i]);
            mread(5'h06, 16'(i % 2));
            chk("remote fault", {15'h0000, PAGES[i][13]}, {15'h0000, rf});
            chk("fd10", {15'h0000, PAGES[i][11]}, {15'h0000, fd10});
            chk("protocol", (sel <= 5'h04) ? {11'h000, sel} : 16'h0000, {13'h0, proto});
        end
        // Page and restart in one cycle: page result wins
        @(negedge clk_sys_in);
        {p_word, p_cap, p_send, restart} = {PAGES[5], 3'h7};
        @(negedge clk_sys_in);
        {p_send, restart} = 2'h0;
        mread(5'h06, 16'h0001);
        @(negedge clk_sys_in);
        restart = 1'b1;
        @(negedge clk_sys_in);
        restart = 1'b0;
        mread(5'h06, 16'h0000);
        mwrite(5'h05, 16'hffff);
        mwrite(5'h06, 16'hffff);
        mwrite(5'h1f, 16'hffff);
        mread(5'h05, PAGES[5]);
        mread(5'h06, 16'h0000);
        $display("test partner_pages done");
        m100 = 1'b1;
        mwrite(5'h10, 16'hfffe);
        mread(5'h10, 16'hfff2);
        chk("inversion", 16'h0001, {15'h0000, rx_inv});
        chk("bypass", 16'h0001, {15'h0000, bypass});
        chk("clock stop", 16'h0000, {15'h0000, clk_stop});
        mwrite(5'h10, 16'h0010);
        mread(5'h10, 16'h0000);
        chk("inversion", 16'h0000, {15'h0000, rx_inv});
        chk("bypass", 16'h0000, {15'h0000, bypass});
        $display("test vendor_writes done");
        m100 = 1'b0;
        {m10, an_active, reversed} = 3'h7;
        idle(4);
        chk("auto inversion", 16'h0001, {15'h0000, rx_inv});
        mread(5'h10, 16'h0010);
        {an_active, reversed} = 2'h0;
        idle(3);
        chk("held inversion", 16'h0001, {15'h0000, rx_inv});
        mwrite(5'h10, 16'h0020);
        {an_active, reversed} = 2'h3;
        idle(4);
        chk("disabled inversion", 16'h0000, {15'h0000, rx_inv});
        mread(5'h10, 16'h0020);
        {m10, an_active, reversed} = 3'h0;
        $display("test polarity done");
        m100 = 1'b1;
        mwrite(5'h10, 16'h0001);
        idle(2);
        chk("clock stop idle", 16'h0001, {15'h0000, clk_stop});
        rx_active = 1'b1;
        idle(2);
        chk("clock stop data", 16'h0000, {15'h0000, clk_stop});
        rx_active = 1'b0;
        loopback = 1'b1;
        idle(2);
        chk("clock stop loop", 16'h0000, {15'h0000, clk_stop});
        loopback = 1'b0;
        m100 = 1'b0;
        idle(2);
        chk("clock stop 10M", 16'h0000, {15'h0000, clk_stop});
        $display("test clock_gating done");
        reset_in = 1'b1;
        idle(2);
        reset_in = 1'b0;
        mread(5'h10, 16'h0140);
        mread(5'h05, 16'h0000);
        $display("test second_reset done");
        wrap_up();
    end
endmodule : tb_ppav_regs
